// [hdl/imc_pkg.sv]
// Purpose: shared constants for the input mode control block
// Assumes: one mainframe unit with fifteen input card slots
// Notes: all offsets are byte addresses on a 32-bit APB bus
`default_nettype none
package imc_pkg;
  // geometry
  localparam int NSLOT = 15;
  localparam int DW = 12;
  localparam int SLOT_W = 4;
  localparam int UNIT_W = 4;
  localparam logic [3:0] SLOT_LAST = 4'he;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_RET = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  // control word fields
  localparam int CTRL_IEN_BIT = 8;
  localparam int CTRL_ISL_BIT = 7;
  localparam int CTRL_TME_BIT = 4;
  localparam int CTRL_UNIT_LSB = 0;
  // address word fields
  localparam int ADDR_SLOT_LSB = 12;
  localparam int ADDR_GATE_BIT = 16;
  // return data fields
  localparam int RET_IRQ_BIT = 15;
  // status fields
  localparam int STAT_FLAG_BIT = 15;
  localparam int STAT_CTF_BIT = 16;
  localparam int STAT_HS_BIT = 17;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [3:0] SLOT_RST = 4'h0;
  // unit number answered by this mainframe
  localparam logic [3:0] UNIT_ID = 4'h0;
  // handshake flag delay
  localparam int HS_DELAY_US = 40;
  localparam int CLK_MHZ = 10;
  localparam logic [8:0] HS_COUNT = 9'(HS_DELAY_US * CLK_MHZ);
  // handshake generator states
  typedef enum logic [0:0] {
    HS_RDY = 1'b0,
    HS_BUSY = 1'b1
  } hs_state_t;
endpackage
`default_nettype wire

// [hdl/input_mode_control.sv]
// Purpose: input mode control of a card mainframe, host reached over APB
// Assumes: cards and external devices outside the 10 MHz clock domain
// Notes: per-slot input card gate/flag logic is included here
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module input_mode_control (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [179:0] DEV_DATA,
  input wire logic [14:0] DEV_FLAG,
  input wire logic [14:0] STORE_JMP,
  input wire logic [14:0] ARM_JMP,
  output logic [14:0] DEV_GATE,
  output logic HOST_FLAG,
  output logic [15:0] RET_DATA
);

  // bus and mode state
  logic [15:0] ctrl_r;
  logic [3:0] slot_r;
  logic ien_q_r;
  logic [31:0] rdata_r;
  logic slverr_r;
  logic wr_en;
  logic ctrl_wr;
  logic addr_wr;
  logic gate_pulse;
  logic [3:0] gate_slot;
  logic input_select_mode;
  logic interrupt_search_enable;
  logic timed_flag_mode;
  logic unit_sel;
  logic ien_rise;

  // synchronisers
  logic [14:0] flag_s1_r;
  logic [14:0] flag_s2_r;
  logic [14:0] flag_s3_r;
  logic [179:0] data_s1_r;
  logic [179:0] data_s2_r;
  logic [14:0] store_s1_r;
  logic [14:0] store_s2_r;
  logic [14:0] arm_s1_r;
  logic [14:0] arm_s2_r;
  logic [14:0] flag_fall;

  // card state
  logic [14:0] active_r;
  logic [14:0] dev_gate_r;
  logic [14:0] rdy_r;
  logic [11:0] card_data_r [imc_pkg::NSLOT];
  logic [14:0] common_timing_flag;
  logic ctf_or;
  logic [15:0] ret_r;
  logic [15:0] ret_nxt;

  // handshake generator
  imc_pkg::hs_state_t hs_state_r;
  logic [8:0] hs_cnt_r;
  logic [8:0] hs_age_r;

  assign wr_en = PSEL & PENABLE & PWRITE;
  assign ctrl_wr = wr_en & (PADDR == imc_pkg::OFF_CTRL);
  assign addr_wr = wr_en & (PADDR == imc_pkg::OFF_ADDR);
  assign gate_pulse = addr_wr & PWDATA[imc_pkg::ADDR_GATE_BIT];
  // low twelve bits of an address word carry nothing
  assign gate_slot = PWDATA[imc_pkg::ADDR_SLOT_LSB +: imc_pkg::SLOT_W];

  assign input_select_mode = ctrl_r[imc_pkg::CTRL_ISL_BIT];
  assign interrupt_search_enable = ctrl_r[imc_pkg::CTRL_IEN_BIT];
  assign timed_flag_mode = ctrl_r[imc_pkg::CTRL_TME_BIT];
  // one unit of sixteen; 16 x 15 slots give the 240-card search space
  assign unit_sel = ctrl_r[imc_pkg::CTRL_UNIT_LSB +: imc_pkg::UNIT_W]
                    == imc_pkg::UNIT_ID;
  assign ien_rise = interrupt_search_enable & ~ien_q_r;

  // control word: mode bits and unit kept until the next one
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctrl_r <= imc_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      slot_r <= imc_pkg::SLOT_RST;
    end else if (addr_wr) begin
      slot_r <= gate_slot;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ien_q_r <= 1'b0;
    end else begin
      ien_q_r <= interrupt_search_enable;
    end
  end

  // apb read data and error captured in the setup cycle
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rdata_r <= 32'h0;
      slverr_r <= 1'b0;
    end else if (PSEL & ~PENABLE) begin
      slverr_r <= 1'b0;
      case (PADDR)
        imc_pkg::OFF_CTRL: rdata_r <= {16'h0, ctrl_r};
        imc_pkg::OFF_ADDR: rdata_r <= {16'h0, slot_r, 12'h0};
        imc_pkg::OFF_RET: rdata_r <= {16'h0, ret_r};
        imc_pkg::OFF_STAT: begin
          rdata_r <= {14'h0, hs_state_r == imc_pkg::HS_BUSY, ctf_or,
                      HOST_FLAG, active_r};
        end
        default: begin
          rdata_r <= 32'h0;
          slverr_r <= 1'b1;
        end
      endcase
    end
  end

  assign PRDATA = rdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = slverr_r & PSEL & PENABLE;

  // pins from cards and devices cross in through two flops
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      flag_s1_r <= 15'h0;
      flag_s2_r <= 15'h0;
      flag_s3_r <= 15'h0;
      data_s1_r <= 180'h0;
      data_s2_r <= 180'h0;
      store_s1_r <= 15'h0;
      store_s2_r <= 15'h0;
      arm_s1_r <= 15'h0;
      arm_s2_r <= 15'h0;
    end else begin
      flag_s1_r <= DEV_FLAG;
      flag_s2_r <= flag_s1_r;
      flag_s3_r <= flag_s2_r;
      data_s1_r <= DEV_DATA;
      data_s2_r <= data_s1_r;
      store_s1_r <= STORE_JMP;
      store_s2_r <= store_s1_r;
      arm_s1_r <= ARM_JMP;
      arm_s2_r <= arm_s1_r;
    end
  end

  // device flag going ready is its trailing edge
  assign flag_fall = flag_s3_r & ~flag_s2_r;

  genvar gi;
  generate
    for (gi = 0; gi < imc_pkg::NSLOT; gi = gi + 1) begin : g_card
      logic hit_gate;
      logic act_set;
      logic act_clr;
      logic ctf_en;

      assign hit_gate = gate_pulse & unit_sel & (gate_slot == 4'(gi));
      // select activation, or arming by interrupt-enable via jumper
      assign act_set = (hit_gate & input_select_mode)
                       | (ien_rise & arm_s2_r[gi]);
      assign act_clr = hit_gate & ~input_select_mode;

      // activation survives input-select dropping later
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          active_r[gi] <= 1'b0;
        end else if (act_set) begin
          active_r[gi] <= 1'b1;
        end else if (act_clr) begin
          active_r[gi] <= 1'b0;
        end
      end

      // device gate starts a transfer, ends when the device is ready
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          dev_gate_r[gi] <= 1'b0;
        end else if (act_set) begin
          dev_gate_r[gi] <= 1'b1;
        end else if (act_clr | flag_fall[gi]) begin
          dev_gate_r[gi] <= 1'b0;
        end
      end

      // ready flag: device edge wins over the clear
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          rdy_r[gi] <= 1'b0;
        end else if (flag_fall[gi] & active_r[gi]) begin
          rdy_r[gi] <= 1'b1;
        end else if (act_clr | act_set) begin
          rdy_r[gi] <= 1'b0;
        end
      end

      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          card_data_r[gi] <= 12'h0;
        end else if (~store_s2_r[gi] | flag_fall[gi]) begin
          card_data_r[gi] <= data_s2_r[gi*imc_pkg::DW +: imc_pkg::DW];
        end
      end

      // search: all active cards; dedicated: the addressed card only
      assign ctf_en = active_r[gi] & timed_flag_mode & (interrupt_search_enable
                      | (input_select_mode & (slot_r == 4'(gi))));
      assign common_timing_flag[gi] = ctf_en & rdy_r[gi];

      chk_gate_activates: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (hit_gate && input_select_mode) |=> (active_r[gi] && dev_gate_r[gi] && DEV_GATE[gi]))
        else $error("addressed gate in select mode did not activate");

      chk_deactivate_card: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (act_clr && !act_set) |=> (!active_r[gi] && !DEV_GATE[gi]))
        else $error("gate with select off did not deactivate");

      chk_inactive_no_ready: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (!active_r[gi] && !rdy_r[gi]) |=> !rdy_r[gi])
        else $error("inactive card signalled data ready");

      chk_arm_on_enable: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (interrupt_search_enable && !ien_q_r && arm_s2_r[gi]) |=> active_r[gi])
        else $error("jumpered card not armed by interrupt enable");

      chk_storage_hold: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (store_s2_r[gi] && !flag_fall[gi]) |=> $stable(card_data_r[gi]))
        else $error("stored data changed without device flag edge");

      chk_return_route: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (input_select_mode && unit_sel && slot_r == 4'(gi)) |=>
          (RET_DATA[11:0] == $past(card_data_r[gi]) &&
           RET_DATA[imc_pkg::RET_IRQ_BIT] == $past(rdy_r[gi])))
        else $error("return lines do not carry addressed card");

      chk_search_flag: assert property (@(posedge CLK_SYS)
        disable iff (SYS_RST)
        (interrupt_search_enable && timed_flag_mode && active_r[gi] && rdy_r[gi]) |-> (ctf_or && HOST_FLAG))
        else $error("ready card in search mode did not raise flag");
    end
  endgenerate

  assign DEV_GATE = dev_gate_r;
  assign ctf_or = |common_timing_flag;

  // return data mux, slot 15 reads as zero
  always_comb begin
    ret_nxt = 16'h0;
    if (input_select_mode & unit_sel & (slot_r <= imc_pkg::SLOT_LAST)) begin
      for (int j = 0; j < imc_pkg::NSLOT; j++) begin
        if (slot_r == 4'(j)) begin
          ret_nxt[11:0] = card_data_r[j];
          ret_nxt[imc_pkg::RET_IRQ_BIT] = rdy_r[j];
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ret_r <= 16'h0;
    end else begin
      ret_r <= ret_nxt;
    end
  end

  assign RET_DATA = ret_r;

  // handshake generator: busy from each gate until the delay runs out
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      hs_state_r <= imc_pkg::HS_RDY;
      hs_cnt_r <= 9'h0;
    end else begin
      case (hs_state_r)
        imc_pkg::HS_RDY: begin
          if (gate_pulse) begin
            hs_state_r <= imc_pkg::HS_BUSY;
            hs_cnt_r <= imc_pkg::HS_COUNT - 9'h1;
          end
        end
        imc_pkg::HS_BUSY: begin
          if (gate_pulse) begin
            hs_cnt_r <= imc_pkg::HS_COUNT - 9'h1;
          end else if (hs_cnt_r == 9'h0) begin
            hs_state_r <= imc_pkg::HS_RDY;
          end else begin
            hs_cnt_r <= hs_cnt_r - 9'h1;
          end
        end
        default: begin
          hs_state_r <= imc_pkg::HS_RDY;
          hs_cnt_r <= 9'h0;
        end
      endcase
    end
  end

  // flag source: card timing flags or the handshake generator
  assign HOST_FLAG = timed_flag_mode ? ctf_or
                         : (hs_state_r == imc_pkg::HS_RDY);

  // cycles since the last gate, for checking the handshake delay
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      hs_age_r <= 9'h0;
    end else if (gate_pulse) begin
      hs_age_r <= 9'h1;
    end else if (hs_age_r != 9'h1ff) begin
      hs_age_r <= hs_age_r + 9'h1;
    end
  end

  chk_handshake_delay: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    (hs_state_r == imc_pkg::HS_BUSY) ##1 (hs_state_r == imc_pkg::HS_RDY)
      |-> ($past(hs_age_r) == imc_pkg::HS_COUNT))
    else $error("handshake ready not 400 cycles after gate");

  chk_handshake_busy: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    (gate_pulse && !timed_flag_mode && !ctrl_wr) |=> !HOST_FLAG [*8])
    else $error("handshake flag not busy after gate");

  chk_flag_source: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    timed_flag_mode |-> (HOST_FLAG == ctf_or))
    else $error("timed flag mode not steering host flag");

  chk_mode_store: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    ctrl_wr ##1 !ctrl_wr |-> ctrl_r == $past(PWDATA[15:0]))
    else $error("control word not kept until next one");

  chk_slot_decode: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    addr_wr |=> (slot_r == $past(PWDATA[15:12])))
    else $error("slot not taken from address bits 15-12");

  chk_no_unit_no_data: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
    (!input_select_mode || !unit_sel) |=> (RET_DATA == 16'h0))
    else $error("return data driven outside select mode");

endmodule // input_mode_control
`default_nettype wire

// [tb/ext_devices.sv]
// Purpose: external devices behind the fifteen input card slots
// Assumes: flag high is busy, a falling flag means data ready
// Notes: data turns to the inverse pattern once the device is busy again
`timescale 1ns/100ps
`default_nettype none
module ext_devices (
  input wire logic clk,
  input wire logic [7:0] lat,
  input wire logic [14:0] gate,
  output logic [179:0] data,
  output logic [14:0] flag
);
  int cnt [15];
  initial begin
    flag = '1;
    data = '0;
    foreach (cnt[i]) cnt[i] = 0;
  end
  // answers a gate after lat cycles: data first, flag falls two later
  always @(posedge clk) begin
    for (int i = 0; i < 15; i++) begin
      if (gate[i] && flag[i]) begin
        cnt[i] <= cnt[i] + 1;
        if (cnt[i] == lat) data[12*i +: 12] <= 12'h5a0 | 12'(i);
        if (cnt[i] == lat + 2) flag[i] <= 1'b0;
      end else if (!gate[i] && !flag[i]) begin
        cnt[i] <= 0;
        flag[i] <= 1'b1;
        data[12*i +: 12] <= ~(12'h5a0 | 12'(i));
      end
    end
  end
endmodule // ext_devices
`default_nettype wire

// [tb/tb_input_mode_control.sv]
// Purpose: self-checking bench for input_mode_control
// Assumes: 10 MHz clock, APB slave answers in its own time
// Notes: slot data pattern is 5a0 or slot number
`timescale 1ns/100ps
`default_nettype none
module tb_input_mode_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic host_flag;
  logic [179:0] dev_data;
  logic [14:0] dev_flag;
  logic [14:0] dev_gate;
  logic [14:0] store_jmp = 15'h002a;
  logic [14:0] arm_jmp = 15'h0000;
  logic [15:0] ret_data;
  logic [7:0] lat = 8'h02;
  logic [31:0] q;
  logic err;
  int fails = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  input_mode_control dut_u (
    .CLK_SYS(clk),
    .SYS_RST(rst),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .DEV_DATA(dev_data),
    .DEV_FLAG(dev_flag),
    .STORE_JMP(store_jmp),
    .ARM_JMP(arm_jmp),
    .DEV_GATE(dev_gate),
    .HOST_FLAG(host_flag),
    .RET_DATA(ret_data)
  );
  ext_devices ext_u (
    .clk(clk),
    .lat(lat),
    .gate(dev_gate),
    .data(dev_data),
    .flag(dev_flag)
  );
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (!ok) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // one transfer: setup, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(pready === 1'b1, "apb timeout");
    if (pready !== 1'b1) test_done();
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_hf(input logic v);
    int n;
    n = 0;
    while (host_flag !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(host_flag === v, "flag wait");
    if (host_flag !== v) test_done();
  endtask
  function automatic logic [31:0] adr(input int s, input logic g);
    return {15'h0, g, 4'(s), 12'h000};
  endfunction
  function automatic logic [11:0] pat(input int s);
    return 12'h5a0 | 12'(s);
  endfunction
  task automatic t_reset;
    chk(ret_data === 16'h0 && host_flag === 1'b1, "reset outputs");
    chk(dev_gate === 15'h0, "reset gates");
    apb(1'b0, imc_pkg::OFF_CTRL, 32'h0);
    chk(q === 32'h0, "ctrl reset");
    apb(1'b0, 8'h10, 32'h0);
    chk(q === 32'h0 && err === 1'b1, "unmapped read");
  endtask
  task automatic t_handshake;
    apb(1'b1, imc_pkg::OFF_CTRL, 32'h080);
    apb(1'b1, imc_pkg::OFF_ADDR, adr(3, 1'b1) | 32'hfff);
    @(posedge clk);
    chk(dev_gate[3] === 1'b1 && host_flag === 1'b0, "gate");
    repeat (399) @(posedge clk);
    chk(host_flag === 1'b0, "flag early");
    @(posedge clk);
    chk(host_flag === 1'b1, "flag late");
    chk(ret_data === {1'b1, 3'b000, pat(3)}, "ret data");
    chk(dev_gate[3] === 1'b0, "gate end");
    apb(1'b0, imc_pkg::OFF_ADDR, 32'h0);
    chk(q === 32'h3000, "addr low bits");
  endtask
  task automatic t_store;
    apb(1'b1, imc_pkg::OFF_ADDR, adr(4, 1'b1));
    repeat (30) @(posedge clk);
    chk(ret_data === {1'b1, 3'b000, ~pat(4)}, "pass through");
  endtask
  task automatic t_drop;
    apb(1'b1, imc_pkg::OFF_CTRL, 32'h0);
    apb(1'b0, imc_pkg::OFF_STAT, 32'h0);
    chk(q[4:3] === 2'b11, "kept active");
    chk(ret_data === 16'h0, "return off");
    apb(1'b1, imc_pkg::OFF_ADDR, adr(3, 1'b1));
    apb(1'b1, imc_pkg::OFF_ADDR, adr(4, 1'b1));
    apb(1'b1, imc_pkg::OFF_CTRL, 32'h080);
    apb(1'b1, imc_pkg::OFF_ADDR, adr(3, 1'b0));
    apb(1'b0, imc_pkg::OFF_STAT, 32'h0);
    chk(q[4:3] === 2'b00 && ret_data[15] === 1'b0, "deactivated");
  endtask
  task automatic t_search;
    lat <= 8'd40;
    apb(1'b1, imc_pkg::OFF_ADDR, adr(1, 1'b1));
    apb(1'b1, imc_pkg::OFF_ADDR, adr(5, 1'b1));
    apb(1'b1, imc_pkg::OFF_CTRL, 32'h110);
    repeat (2) @(posedge clk);
    chk(host_flag === 1'b0, "search busy");
    wait_hf(1'b1);
    apb(1'b1, imc_pkg::OFF_CTRL, 32'h080);
    apb(1'b1, imc_pkg::OFF_ADDR, adr(5, 1'b0));
    repeat (2) @(posedge clk);
    chk(ret_data === {1'b1, 3'b000, pat(5)}, "search read");
    apb(1'b1, imc_pkg::OFF_CTRL, 32'h081);
    repeat (2) @(posedge clk);
    chk(ret_data === 16'h0, "unit mismatch");
  endtask
  task automatic t_timed;
    apb(1'b1, imc_pkg::OFF_CTRL, 32'h090);
    apb(1'b1, imc_pkg::OFF_ADDR, adr(6, 1'b1));
    repeat (2) @(posedge clk);
    chk(host_flag === 1'b0, "dedicated busy");
    wait_hf(1'b1);
  endtask
  task automatic t_arm;
    @(posedge clk);
    arm_jmp <= 15'h0080;
    repeat (3) @(posedge clk);
    apb(1'b1, imc_pkg::OFF_CTRL, 32'h100);
    repeat (3) @(posedge clk);
    apb(1'b0, imc_pkg::OFF_STAT, 32'h0);
    chk(q[8:7] === 2'b01 && dev_gate[7] === 1'b1, "armed");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_handshake();
    t_store();
    t_drop();
    t_search();
    t_timed();
    t_arm();
    test_done();
  end
endmodule // tb_input_mode_control
`default_nettype wire
